// ==== common/redriver_pkg.sv ====
// constants for the redriver lane configuration block: register map,
// field positions, reset values, strap levels and termination codes.
// assumes an 8-bit register space reached over a two-wire serial target.
package redriver_pkg;
  // ==========================================================================
  // register offsets
  localparam logic [7:0] OFS_TERM_CTL  = 8'h0B; // termination_control
  localparam logic [7:0] OFS_SWING_CTL = 8'h0C; // swing_control
  localparam logic [7:0] OFS_GEQ_CTL   = 8'h0D; // global_equalizer_control
  localparam logic [7:0] OFS_SD_STAT   = 8'h20; // signal_detect_status
  localparam logic [7:0] OFS_LEQ_A     = 8'h4E; // lane_equalizer_a
  localparam logic [7:0] OFS_LEQ_B     = 8'h4F; // lane_equalizer_b
  // ==========================================================================
  // reset values (global control, auto termination, detect enabled)
  localparam logic [7:0] RST_TERM_CTL  = 8'h11;
  localparam logic [7:0] RST_SWING_CTL = 8'h00;
  localparam logic [7:0] RST_GEQ_CTL   = 8'h00;
  localparam logic [7:0] RST_LEQ       = 8'h00;
  // ==========================================================================
  // field positions
  localparam int TERM_DETECT_EN_BIT = 0;  // signal_detect_enable
  localparam int TERM_RATIO_BIT     = 1;  // clock_ratio_flag
  localparam int TERM_SEL_LSB       = 3;  // termination select [4:3]
  localparam int TERM_DSLEW_BIT     = 6;  // data lane slow edges
  localparam int TERM_CSLEW_BIT     = 7;  // clock lane slow edges
  localparam int SWING_DATA_LSB     = 5;  // data_swing_field [7:5]
  localparam int SWING_CLK_LSB      = 2;  // clock_swing_field [4:2]
  localparam int GEQ_CLK_LSB        = 1;  // clock lane field [2:1]
  localparam int GEQ_DATA_LSB       = 3;  // data lane field [6:3]
  localparam int GEQ_INDEP_BIT      = 7;  // independent lane mode
  localparam int STAT_VALID_BIT     = 5;  // valid clock detected
  // ==========================================================================
  // three-level strap encodings
  localparam logic [1:0] LVL_LOW   = 2'b00;
  localparam logic [1:0] LVL_HIGH  = 2'b01;
  localparam logic [1:0] LVL_FLOAT = 2'b10;
  // termination select codes
  localparam logic [1:0] TERM_150_300 = 2'b00;
  localparam logic [1:0] TERM_NONE    = 2'b01;
  localparam logic [1:0] TERM_AUTO    = 2'b10;
  localparam logic [1:0] TERM_75_150  = 2'b11;
  // serial target address, arbitrary value
  localparam logic [6:0] TARGET_ADDR = 7'h2C;
endpackage : redriver_pkg

// ==== core/redriver_lane_config.sv ====
// register bank and configuration logic of a four-lane redriver.
// assumes rst_n is the output-enable pin, all pins synchronous to clk,
// and the analog side consuming the registered codes below.
`timescale 1ns/10ps
// Overview of operation
// - global 4-bit code selects sixteen rising gains
// - three-level strap pair maps to nine gains
// - independent mode takes per-lane register nibbles
// - clock lane uses own 2-bit field
// - no valid clock keeps lanes in standby
// - signal detect enable resets to enabled
// - detect result readable as status bit
// - 2-bit field selects source termination
// - termination strap selects from three levels
// - clock ratio flag forces 75-150 ohm
// - output enable low keeps transmitters off
// - swing fields route to data, clock lanes
// - clock slew by strap, both by register
// - flag follows snooped clock ratio bit
module redriver_lane_config
  import redriver_pkg::*;
#(
  parameter logic [6:0] TARGET_ADDRESS = TARGET_ADDR // serial target address
)(
  input  wire logic       clk,
  input  wire logic       rst_n,              // output-enable pin
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  input  wire logic       i2c_enable_pin,     // high: register programming
  input  wire logic [1:0] eq_strap_low_pin,   // three-level code
  input  wire logic [1:0] eq_strap_high_pin,  // three-level code
  input  wire logic [1:0] term_strap_pin,     // three-level code
  input  wire logic       slew_strap_pin,
  input  wire logic       clock_valid,        // analog detector result
  input  wire logic       snoop_ratio_valid,  // snooped ratio bit seen
  input  wire logic       snoop_ratio_value,
  input  wire logic       hpd_low,            // sink unplugged, clears flag
  output logic [3:0]      eq_d0,
  output logic [3:0]      eq_d1,
  output logic [3:0]      eq_d2,
  output logic [3:0]      eq_clock_lane,
  output logic [4:0]      receiver_equalizer_gain, // half-dB units, lane d0
  output logic [1:0]      term_select,
  output logic            tx_enable,
  output logic            data_input_enable,
  output logic [2:0]      data_swing_field,
  output logic [2:0]      clock_swing_field,
  output logic            clock_slew_slow,
  output logic            data_slew_slow,
  output logic            clock_ratio_flag
);
  // elaboration check: the general call address would answer every controller
  if (TARGET_ADDRESS == 7'h00)
  begin : g_bad_address
    $error("general call address not allowed");
  end

  // ==========================================================================
  // register storage
  logic [7:0] term_ctl;   // termination_control
  logic [7:0] swing_ctl;  // swing_control
  logic [7:0] geq_ctl;    // global_equalizer_control
  logic [7:0] leq_a;      // lane_equalizer_a
  logic [7:0] leq_b;      // lane_equalizer_b
  logic       valid_q;    // registered detect result

  // ==========================================================================
  // serial target state
  typedef enum logic [6:0] {
    ST_IDLE = 7'b0000001, ST_ADDR = 7'b0000010, ST_AACK = 7'b0000100,
    ST_WRITE = 7'b0001000, ST_WACK = 7'b0010000, ST_READ = 7'b0100000,
    ST_RACK = 7'b1000000
  } serial_state_type;
  serial_state_type state;
  logic [3:0] bit_cnt;    // bits of current byte
  logic [7:0] shreg;      // shift register
  logic [7:0] pointer;    // register pointer
  logic       first_byte; // next written byte is the pointer
  logic       read_mode;  // address byte had read bit
  logic       scl_q;      // previous scl
  logic       sda_q;      // previous sda

  wire scl_rise  = scl_in & ~scl_q;
  wire scl_fall  = ~scl_in & scl_q;
  wire start_cnd = scl_in & scl_q & sda_q & ~sda_in;
  wire stop_cnd  = scl_in & scl_q & ~sda_q & sda_in;
  wire byte_done = bit_cnt == 4'd8;
  wire addr_hit  = shreg[7:1] == TARGET_ADDRESS;
  // register write strobe at the falling edge ending the eighth bit of a data byte
  wire wr_stb    = (state == ST_WRITE) & scl_fall & byte_done & ~first_byte;

  // read mux; unmapped offsets read as zero
  logic [7:0] rd_data;
  always_comb
  begin
    unique case (pointer)
      OFS_TERM_CTL:  rd_data = term_ctl;
      OFS_SWING_CTL: rd_data = swing_ctl;
      OFS_GEQ_CTL:   rd_data = geq_ctl;
      OFS_SD_STAT:   rd_data = 8'(valid_q) << STAT_VALID_BIT;
      OFS_LEQ_A:     rd_data = leq_a;
      OFS_LEQ_B:     rd_data = leq_b;
      default:       rd_data = 8'h00;
    endcase
  end

  // edge history of the serial pins
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end
    else
    begin
      scl_q <= scl_in;
      sda_q <= sda_in;
    end
  end

  // serial target: start/stop override, sample on rise, drive on fall
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state      <= ST_IDLE;
      bit_cnt    <= 4'd0;
      shreg      <= 8'h00;
      pointer    <= 8'h00;
      first_byte <= 1'b0;
      read_mode  <= 1'b0;
      sda_oe     <= 1'b0;
    end
    else if (start_cnd)
    begin
      state   <= ST_ADDR;
      bit_cnt <= 4'd0;
      sda_oe  <= 1'b0;
    end
    else if (stop_cnd)
    begin
      state  <= ST_IDLE;
      sda_oe <= 1'b0;
    end
    else if (scl_rise)
    begin
      // master nack ends a read burst
      if (state == ST_RACK && sda_in)
        state <= ST_IDLE;
      else if (state inside {ST_ADDR, ST_WRITE})
      begin
        shreg   <= {shreg[6:0], sda_in};
        bit_cnt <= bit_cnt + 4'd1;
      end
      else if (state == ST_READ)
        bit_cnt <= bit_cnt + 4'd1;
    end
    else if (scl_fall)
    begin
      unique case (state)
        ST_ADDR:
        begin
          // ack only our own address
          if (byte_done && addr_hit)
          begin
            sda_oe    <= 1'b1;
            read_mode <= shreg[0];
            state     <= ST_AACK;
          end
          else if (byte_done)
            state <= ST_IDLE;
        end
        ST_AACK:
        begin
          bit_cnt    <= 4'd0;
          first_byte <= 1'b1;
          if (read_mode)
          begin
            shreg  <= {rd_data[6:0], 1'b0};
            sda_oe <= ~rd_data[7];
            state  <= ST_READ;
          end
          else
          begin
            sda_oe <= 1'b0;
            state  <= ST_WRITE;
          end
        end
        ST_WRITE:
        begin
          if (byte_done)
          begin
            sda_oe     <= 1'b1;
            first_byte <= 1'b0;
            // first byte sets the pointer, later bytes auto-increment it
            pointer    <= first_byte ? shreg : pointer + 8'd1;
            state      <= ST_WACK;
          end
        end
        ST_WACK:
        begin
          sda_oe  <= 1'b0;
          bit_cnt <= 4'd0;
          state   <= ST_WRITE;
        end
        ST_READ:
        begin
          if (byte_done)
          begin
            sda_oe  <= 1'b0;
            pointer <= pointer + 8'd1;
            state   <= ST_RACK;
          end
          else
          begin
            sda_oe <= ~shreg[7];
            shreg  <= {shreg[6:0], 1'b0};
          end
        end
        ST_RACK:
        begin
          bit_cnt <= 4'd0;
          shreg   <= {rd_data[6:0], 1'b0};
          sda_oe  <= ~rd_data[7];
          state   <= ST_READ;
        end
        ST_IDLE:
          sda_oe <= 1'b0;
      endcase
    end
  end

  // ==========================================================================
  // register writes; all fields return to their reset values while output enable is low
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      term_ctl  <= RST_TERM_CTL;
      swing_ctl <= RST_SWING_CTL;
      geq_ctl   <= RST_GEQ_CTL;
      leq_a     <= RST_LEQ;
      leq_b     <= RST_LEQ;
    end
    else
    begin
      if (wr_stb && pointer == OFS_TERM_CTL)
        term_ctl <= shreg;
      // snoop set wins over unplug clear
      if (snoop_ratio_valid)
        term_ctl[TERM_RATIO_BIT] <= snoop_ratio_value;
      else if (hpd_low)
        term_ctl[TERM_RATIO_BIT] <= 1'b0;
      if (wr_stb && pointer == OFS_SWING_CTL)
        swing_ctl <= shreg;
      if (wr_stb && pointer == OFS_GEQ_CTL)
        geq_ctl <= shreg;
      if (wr_stb && pointer == OFS_LEQ_A)
        leq_a <= shreg;
      if (wr_stb && pointer == OFS_LEQ_B)
        leq_b <= shreg;
    end
  end

  // ==========================================================================
  // strap decoding; undefined level 11 is treated as floating
  // three-level strap gains
  function automatic logic [3:0] strap_eq(input logic [1:0] hi, input logic [1:0] lo);
    logic [1:0] h;
    logic [1:0] l;
    h = (hi == LVL_LOW) ? 2'd0 : (hi == LVL_HIGH) ? 2'd2 : 2'd1;
    l = (lo == LVL_LOW) ? 2'd0 : (lo == LVL_HIGH) ? 2'd2 : 2'd1;
    unique case ({h, l})
      4'h0: strap_eq = 4'h0;  // 00 2 dB
      4'h1: strap_eq = 4'h1;  // 0Z 3 dB
      4'h2: strap_eq = 4'h3;  // 01 5 dB
      4'h4: strap_eq = 4'h4;  // Z0 6.5 dB
      4'h5: strap_eq = 4'h6;  // ZZ 8.5 dB
      4'h6: strap_eq = 4'h8;  // Z1 10 dB
      4'h8: strap_eq = 4'h9;  // 10 11 dB
      4'h9: strap_eq = 4'hD;  // 1Z 14.5 dB
      default: strap_eq = 4'hF; // 11 15.5 dB
    endcase
  endfunction : strap_eq

  // code to gain in half-dB steps, strictly rising
  function automatic logic [4:0] gain_half_db(input logic [3:0] code);
    logic [4:0] table_v [16];
    table_v = '{5'h04, 5'h06, 5'h08, 5'h0A, 5'h0D, 5'h0F, 5'h11, 5'h12,
                5'h14, 5'h16, 5'h18, 5'h1A, 5'h1C, 5'h1D, 5'h1E, 5'h1F};
    gain_half_db = table_v[code];
  endfunction : gain_half_db

  // ==========================================================================
  // effective lane codes, lane order d2, d1, d0, clock
  wire        indep     = geq_ctl[GEQ_INDEP_BIT];
  wire [15:0] lane_nib  = {leq_b, leq_a};
  wire [3:0]  strap_code = strap_eq(eq_strap_high_pin, eq_strap_low_pin);
  logic [3:0] next_code [4];
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : g_lane
      assign next_code[g] = !i2c_enable_pin ? strap_code :
                            indep ? lane_nib[4*g +: 4] :
                            (g == 3) ? {2'b00, geq_ctl[GEQ_CLK_LSB +: 2]} :
                            geq_ctl[GEQ_DATA_LSB +: 4];
    end
  endgenerate

  // termination: strap levels or field, ratio flag forces 75-150
  wire [1:0] strap_term = (term_strap_pin == LVL_LOW)  ? TERM_150_300 :
                          (term_strap_pin == LVL_HIGH) ? TERM_75_150 : TERM_NONE;
  wire [1:0] reg_term   = term_ctl[TERM_SEL_LSB +: 2];
  wire       ratio      = term_ctl[TERM_RATIO_BIT];
  wire [1:0] sel_term   = !i2c_enable_pin ? strap_term :
                          (reg_term == TERM_AUTO) ? TERM_NONE : reg_term;
  wire [1:0] next_term  = ratio ? TERM_75_150 : sel_term;
  wire       standby    = term_ctl[TERM_DETECT_EN_BIT] & ~clock_valid;

  // ==========================================================================
  // registered outputs; reset holds transmitters off
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      // outputs off while enable pin low
      tx_enable               <= 1'b0;
      data_input_enable       <= 1'b0;
      eq_d2                   <= 4'h0;
      eq_d1                   <= 4'h0;
      eq_d0                   <= 4'h0;
      eq_clock_lane           <= 4'h0;
      receiver_equalizer_gain <= 5'h04;
      term_select             <= TERM_150_300;
      data_swing_field        <= 3'b000;
      clock_swing_field       <= 3'b000;
      clock_slew_slow         <= 1'b0;
      data_slew_slow          <= 1'b0;
      clock_ratio_flag        <= 1'b0;
      valid_q                 <= 1'b0;
      sda_out                 <= 1'b0;
    end
    else
    begin
      tx_enable               <= ~standby;
      data_input_enable       <= ~standby;
      eq_d2                   <= next_code[0];
      eq_d1                   <= next_code[1];
      eq_d0                   <= next_code[2];
      eq_clock_lane           <= next_code[3];
      receiver_equalizer_gain <= gain_half_db(next_code[2]);
      term_select             <= next_term;
      data_swing_field        <= swing_ctl[SWING_DATA_LSB +: 3];
      clock_swing_field       <= swing_ctl[SWING_CLK_LSB +: 3];
      clock_slew_slow         <= i2c_enable_pin ? term_ctl[TERM_CSLEW_BIT] : slew_strap_pin;
      data_slew_slow          <= i2c_enable_pin & term_ctl[TERM_DSLEW_BIT];
      clock_ratio_flag        <= ratio;
      valid_q                 <= clock_valid;
      sda_out                 <= 1'b0;
    end
  end

  // ==========================================================================
  // assertions
  default clocking cb @(posedge clk); endclocking
  // checks start one edge after release, so no attempt begins at the release
  // edge itself and compares against outputs still held in reset
  logic live_q; // high from the first edge after reset release
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      live_q <= 1'b0;
    else
      live_q <= 1'b1;
  end
  default disable iff (!live_q);
  logic wr_seen; // any register write since reset
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      wr_seen <= 1'b0;
    else if (wr_stb)
      wr_seen <= 1'b1;
  end
  sequence snoop_one_s;
    snoop_ratio_valid && snoop_ratio_value;
  endsequence
  chk_standby_gating: assert property (standby |=> !tx_enable && !data_input_enable)
    else $error("lanes active without valid clock");
  chk_detect_default: assert property (!wr_seen |-> term_ctl[TERM_DETECT_EN_BIT])
    else $error("detect enable not set after reset");
  chk_status_bit: assert property (pointer == OFS_SD_STAT |-> rd_data[STAT_VALID_BIT] == $past(clock_valid))
    else $error("status bit does not follow detector");
  chk_ratio_term: assert property (ratio |=> term_select == TERM_75_150)
    else $error("ratio flag did not force termination");
  chk_auto_term: assert property (i2c_enable_pin && !ratio && reg_term == TERM_AUTO |=> term_select == TERM_NONE)
    else $error("auto termination wrong without ratio");
  chk_strap_term: assert property (!i2c_enable_pin && !ratio && term_strap_pin == LVL_LOW |=> term_select == TERM_150_300)
    else $error("termination strap low misdecoded");
  chk_strap_eq: assert property (!i2c_enable_pin && eq_strap_high_pin == LVL_FLOAT && eq_strap_low_pin == LVL_FLOAT |=> eq_d0 == 4'h6)
    else $error("floating straps not 8.5 dB");
  chk_global_eq: assert property (i2c_enable_pin && !indep |=> eq_d0 == $past(geq_ctl[6:3]) && eq_d2 == eq_d0)
    else $error("global equalizer code not applied");
  chk_gain_ends: assert property (eq_d0 == 4'hF |-> receiver_equalizer_gain == 5'h1F)
    else $error("top code not 15.5 dB");
  chk_indep_eq: assert property (i2c_enable_pin && indep |=> eq_d2 == $past(leq_a[3:0]) && eq_clock_lane == $past(leq_b[7:4]))
    else $error("lane nibble not applied");
  chk_clock_eq: assert property (i2c_enable_pin && !indep |=> eq_clock_lane == {2'b00, $past(geq_ctl[2:1])})
    else $error("clock lane field not applied");
  chk_swing_route: assert property (##1 data_swing_field == $past(swing_ctl[7:5]))
    else $error("data swing not routed");
  chk_slew_strap: assert property (!i2c_enable_pin |=> !data_slew_slow && clock_slew_slow == $past(slew_strap_pin))
    else $error("strap slew reached data lanes");
  chk_ratio_snoop: assert property (snoop_one_s |=> ratio ##1 clock_ratio_flag)
    else $error("snooped ratio not captured");
endmodule : redriver_lane_config

// ==== dv/video_link_model.sv ====
// far side of the redriver: clock detector, ratio snoop and sink plug.
// assumes the bench calls these tasks from a process synced to clk.
`timescale 1ns/10ps
module video_link_model (
  input  wire logic clk,
  output logic      clock_valid,
  output logic      snoop_ratio_valid,
  output logic      snoop_ratio_value,
  output logic      hpd_low
);
  // ==========================================================================
  // quiet link at time zero: no clock seen, sink plugged in
  initial
  begin
    clock_valid       = 1'b0;
    snoop_ratio_valid = 1'b0;
    snoop_ratio_value = 1'b0;
    hpd_low           = 1'b0;
  end
  // source clock present or not, sink plugged or not
  task automatic set_link(input logic cv, input logic unplug);
    @(posedge clk);
    clock_valid <= cv;
    hpd_low     <= unplug;
  endtask : set_link
  // one-cycle snoop pulse; the value is not held past the pulse
  task automatic ratio(input logic v);
    @(posedge clk);
    snoop_ratio_valid <= 1'b1;
    snoop_ratio_value <= v;
    @(posedge clk);
    snoop_ratio_valid <= 1'b0;
    snoop_ratio_value <= ~v;
  endtask : ratio
endmodule : video_link_model

// ==== dv/redriver_lane_config_test.sv ====
// self-checking bench of the redriver lane configuration block.
// assumes a pull-up on sda and the serial target at TARGET_ADDR.
`timescale 1ns/10ps
module redriver_lane_config_test;
  import redriver_pkg::*;
  // ==========================================================================
  // signals
  logic       clk, rst_n, scl, sda_m, i2c_en, slew_strap;
  logic [1:0] eq_lo, eq_hi, term_strap, term_select;
  logic       clock_valid, snoop_valid, snoop_value, hpd_low;
  logic       sda_out, sda_oe, tx_enable, data_input_enable;
  logic [3:0] eq_d0, eq_d1, eq_d2, eq_clk;
  logic [4:0] gain;
  logic [2:0] dsw, csw;
  logic       cslew, dslew, ratio_flag, a;
  logic [7:0] rd;
  int         mismatches, check_count;
  wire        sda = sda_m & ~sda_oe; // open drain, pulled up
  // strap pairs {high,low} (low 00, high 01, float 10) and their codes
  localparam logic [3:0] STRAP_LVL [9] = '{4'h0, 4'h2, 4'h1, 4'h8, 4'hA, 4'h9, 4'h4, 4'h6, 4'h5};
  localparam logic [3:0] STRAP_EQ [9] = '{4'h0, 4'h1, 4'h3, 4'h4, 4'h6, 4'h8, 4'h9, 4'hD, 4'hF};
  // gain of each code in half-dB steps
  localparam logic [4:0] GAIN [16] = '{5'h04, 5'h06, 5'h08, 5'h0A, 5'h0D, 5'h0F, 5'h11, 5'h12,
                                       5'h14, 5'h16, 5'h18, 5'h1A, 5'h1C, 5'h1D, 5'h1E, 5'h1F};
  // termination per select code, flag clear (auto falls to none)
  localparam logic [1:0] TERM_EXP [4] = '{TERM_150_300, TERM_NONE, TERM_NONE, TERM_75_150};
  localparam logic [7:0] OFS [6] = '{OFS_TERM_CTL, OFS_SWING_CTL, OFS_GEQ_CTL, OFS_LEQ_A, OFS_LEQ_B, 8'h30};
  localparam logic [7:0] RST [6] = '{RST_TERM_CTL, RST_SWING_CTL, RST_GEQ_CTL, RST_LEQ, RST_LEQ, 8'h00};
  redriver_lane_config u_redriver_lane_config (
    .clk(clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .i2c_enable_pin(i2c_en), .eq_strap_low_pin(eq_lo), .eq_strap_high_pin(eq_hi),
    .term_strap_pin(term_strap), .slew_strap_pin(slew_strap), .clock_valid(clock_valid),
    .snoop_ratio_valid(snoop_valid), .snoop_ratio_value(snoop_value), .hpd_low(hpd_low),
    .eq_d0(eq_d0), .eq_d1(eq_d1), .eq_d2(eq_d2), .eq_clock_lane(eq_clk),
    .receiver_equalizer_gain(gain), .term_select(term_select), .tx_enable(tx_enable),
    .data_input_enable(data_input_enable), .data_swing_field(dsw), .clock_swing_field(csw),
    .clock_slew_slow(cslew), .data_slew_slow(dslew), .clock_ratio_flag(ratio_flag));
  video_link_model u_video_link_model (
    .clk(clk), .clock_valid(clock_valid), .snoop_ratio_valid(snoop_valid),
    .snoop_ratio_value(snoop_value), .hpd_low(hpd_low));
  // ==========================================================================
  // clock, 40 ns period
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // ==========================================================================
  // tasks
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  // one bit: sda set while scl low, four clocks each phase
  task automatic bit_io(input logic v, output logic seen);
    @(posedge clk);
    sda_m <= v;
    repeat (3) @(posedge clk);
    scl <= 1'b1;
    repeat (2) @(posedge clk);
    seen = sda;
    repeat (2) @(posedge clk);
    scl <= 1'b0;
  endtask : bit_io
  // go high: start condition; go low: stop, leaving scl high
  task automatic frame(input logic go);
    @(posedge clk);
    sda_m <= go;
    repeat (3) @(posedge clk);
    scl <= 1'b1;
    repeat (4) @(posedge clk);
    sda_m <= ~go;
    repeat (4) @(posedge clk);
    if (go)
      scl <= 1'b0;
  endtask : frame
  // byte msb first, then the ninth bit (sent released, or master nack)
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(tx[i], s);
      rx[i] = s;
    end
    bit_io(1'b1, s);
    ack = ~s;
  endtask : xfer
  task automatic reg_write(input logic [7:0] ofs, input logic [7:0] d);
    logic [7:0] x;
    frame(1'b1);
    xfer({TARGET_ADDR, 1'b0}, x, a);
    xfer(ofs, x, a);
    xfer(d, x, a);
    check({7'h0, a}, 8'h01);
    frame(1'b0);
  endtask : reg_write
  // pointer write, stop, then a one-byte read ended by nack
  task automatic reg_read(input logic [7:0] ofs, output logic [7:0] d);
    logic [7:0] x;
    frame(1'b1);
    xfer({TARGET_ADDR, 1'b0}, x, a);
    xfer(ofs, x, a);
    frame(1'b0);
    frame(1'b1);
    xfer({TARGET_ADDR, 1'b1}, x, a);
    check({7'h0, a}, 8'h01);
    xfer(8'hFF, d, a);
    frame(1'b0);
  endtask : reg_read
  // let config outputs follow, then sample off the edge
  task automatic settle;
    repeat (3) @(posedge clk);
    #1;
  endtask : settle
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish
  // ==========================================================================
  // watchdog, several times the expected run length
  initial
  begin
    repeat (60000) @(posedge clk);
    mismatches++;
    tally_and_finish;
  end
  // ==========================================================================
  // main sequence
  initial
  begin
    {rst_n, slew_strap, eq_lo, eq_hi, term_strap} = '0;
    {scl, sda_m, i2c_en} = 3'b111;
    mismatches = 0;
    check_count = 0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    settle;
    check({5'h0, sda_out, tx_enable, data_input_enable}, 8'h00);
    u_video_link_model.set_link(1'b1, 1'b0);
    settle;
    check({6'h0, tx_enable, data_input_enable}, 8'h03);
    for (int i = 0; i < 6; i++)
    begin
      reg_read(OFS[i], rd);
      check(rd, RST[i]);
    end
    reg_read(OFS_SD_STAT, rd);
    check({7'h0, rd[5]}, 8'h01);
    u_video_link_model.set_link(1'b0, 1'b0);
    reg_read(OFS_SD_STAT, rd);
    check({6'h0, rd[5], tx_enable}, 8'h00);
    reg_write(OFS_TERM_CTL, 8'h10);
    settle;
    check({7'h0, tx_enable}, 8'h01);
    for (int c = 0; c < 16; c++)
    begin
      reg_write(OFS_GEQ_CTL, {1'b0, 4'(c), 2'(c), 1'b0});
      settle;
      check({eq_d0, eq_d1}, {4'(c), 4'(c)});
      check({eq_d2, 1'b0, gain[4:2]}, {4'(c), 1'b0, GAIN[c][4:2]});
      check({6'h0, gain[1:0]}, {6'h0, GAIN[c][1:0]});
      check({4'h0, eq_clk}, 8'(c % 4));
    end
    reg_write(OFS_LEQ_A, 8'h5A);
    reg_write(OFS_LEQ_B, 8'hC3);
    reg_write(OFS_GEQ_CTL, 8'h80);
    settle;
    check({eq_d1, eq_d2}, 8'h5A);
    check({eq_clk, eq_d0}, 8'hC3);
    check({3'h0, gain}, 8'h0A);
    reg_write(OFS_SWING_CTL, 8'h98);
    reg_write(OFS_TERM_CTL, 8'hC1);
    settle;
    check({2'h0, dsw, csw}, 8'h26);
    check({6'h0, cslew, dslew}, 8'h03);
    for (int s = 0; s < 4; s++)
    begin
      reg_write(OFS_TERM_CTL, {3'h0, 2'(s), 3'h1});
      settle;
      check({6'h0, term_select}, {6'h0, TERM_EXP[s]});
    end
    reg_write(OFS_TERM_CTL, 8'h11);
    u_video_link_model.ratio(1'b1);
    settle;
    check({6'h0, ratio_flag, term_select == TERM_75_150}, 8'h03);
    reg_read(OFS_TERM_CTL, rd);
    check(rd, 8'h13);
    reg_write(OFS_TERM_CTL, 8'h43);
    settle;
    check({6'h0, term_select}, {6'h0, TERM_75_150});
    u_video_link_model.set_link(1'b1, 1'b1);
    settle;
    check({5'h0, ratio_flag, term_select}, {6'h0, TERM_150_300});
    @(posedge clk);
    i2c_en <= 1'b0;
    slew_strap <= 1'b1;
    for (int p = 0; p < 9; p++)
    begin
      {eq_hi, eq_lo} <= STRAP_LVL[p];
      term_strap <= 2'(p % 3 == 0 ? LVL_LOW : p % 3 == 1 ? LVL_FLOAT : LVL_HIGH);
      settle;
      check({4'h0, eq_d0}, {4'h0, STRAP_EQ[p]});
      check({6'h0, term_select}, {6'h0, TERM_EXP[p % 3 == 2 ? 3 : p % 3]});
      @(posedge clk);
    end
    check({6'h0, cslew, dslew}, 8'h02);
    rst_n <= 1'b0;
    settle;
    check({4'h0, tx_enable, data_input_enable, term_select}, 8'h00);
    // release again: termination_control, written before, must be back at its reset value
    @(posedge clk);
    rst_n <= 1'b1;
    reg_read(OFS_TERM_CTL, rd);
    check(rd, RST_TERM_CTL);
    tally_and_finish;
  end
endmodule : redriver_lane_config_test
